// >>> src/alsb_top.sv
// APB status bank for two conversion value logging instances
`timescale 1ns/1ps
module alsb_top #(
    parameter int HALF_DEPTH = alsb_pkg::HALF_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [alsb_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Logging control
    input wire logic ctrl_run,
    input wire alsb_pkg::alsb_setup_t [alsb_pkg::NUM_INST-1:0] setup,
    input wire logic [alsb_pkg::NUM_INST-1:0] log_exec,
    input wire logic [alsb_pkg::NUM_INST-1:0] switch_request,
    // External input blocks, asynchronous pins
    input wire logic [11:0] ext_in,
    // Interrupt
    output logic irq
);

    alsb_pkg::alsb_state_t s_r;
    alsb_pkg::alsb_state_t s_nxt;
    localparam int IRQ_W_L = alsb_pkg::IRQ_W;

    // Trigger switching when method is anything but 0
    function automatic logic is_trigger(input logic [15:0] m);
        return m != 16'h0000; // [R17]
    endfunction

    // Out-of-range block numbers fall back to command switching
    function automatic logic ext_used(input alsb_pkg::alsb_setup_t st);
        return st.condition != 16'h0000 && st.ext_select <= alsb_pkg::EXT_MAX;
    endfunction

    function automatic logic [15:0] method_mon(input alsb_pkg::alsb_setup_t st,
                                               input logic run);
        return (run && st.enable && is_trigger(st.method)) ?
               16'h0001 : 16'h0000; // [R1]
    endfunction

    function automatic logic [15:0] cond_mon(input alsb_pkg::alsb_setup_t st,
                                             input logic run);
        return (run && st.enable && ext_used(st)) ?
               16'h0001 : 16'h0000; // [R2]
    endfunction

    function automatic logic [15:0] ext_mon(input alsb_pkg::alsb_setup_t st,
                                            input logic run);
        return (run && st.enable && ext_used(st)) ?
               st.ext_select : 16'h0000; // [R3] [R4]
    endfunction

    function automatic logic [15:0] half_mon(input alsb_pkg::alsb_half_t h);
        logic [15:0] v;
        v = alsb_pkg::MON_STOPPED;
        if (h == alsb_pkg::ALSB_HALF_A) begin
            v = alsb_pkg::MON_HALF_A; // [R5]
        end else if (h == alsb_pkg::ALSB_HALF_B) begin
            v = alsb_pkg::MON_HALF_B; // [R5]
        end
        return v;
    endfunction

    function automatic logic [9:0] word_index(input logic [11:0] a);
        return a[11:2];
    endfunction

    logic [9:0] idx;
    logic acc_done;
    logic wr_go;
    logic rd_hit;
    logic [15:0] rd_word;
    logic [alsb_pkg::NUM_INST-1:0] wr_done_a;
    logic [alsb_pkg::NUM_INST-1:0] wr_done_b;
    logic [alsb_pkg::NUM_INST-1:0] wr_restart;
    logic wr_stat;
    logic wr_mask;
    logic run_start;

    assign idx = word_index(paddr);
    // Access completes on the edge where the registered ready is seen
    assign acc_done = psel && penable && s_r.pready;
    assign wr_go = acc_done && pwrite && pstrb[0] && pstrb[1];
    assign run_start = ctrl_run && !s_r.run_prev;

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_word = 16'h0000;
        unique case (idx)
            alsb_pkg::IDX_METHOD_MON_1:
                rd_word = method_mon(setup[0], ctrl_run);
            alsb_pkg::IDX_COND_MON_1: rd_word = cond_mon(setup[0], ctrl_run);
            alsb_pkg::IDX_EXT_MON_1: rd_word = ext_mon(setup[0], ctrl_run);
            alsb_pkg::IDX_METHOD_MON_2:
                rd_word = method_mon(setup[1], ctrl_run);
            alsb_pkg::IDX_COND_MON_2: rd_word = cond_mon(setup[1], ctrl_run);
            alsb_pkg::IDX_EXT_MON_2: rd_word = ext_mon(setup[1], ctrl_run);
            alsb_pkg::IDX_HALF_MON_1: rd_word = half_mon(s_r.inst[0].half);
            alsb_pkg::IDX_DONE_A_1: rd_word = {15'h0000, s_r.inst[0].done_a};
            alsb_pkg::IDX_DONE_B_1: rd_word = {15'h0000, s_r.inst[0].done_b};
            alsb_pkg::IDX_COUNT_A_1: rd_word = s_r.inst[0].cnt_a;
            alsb_pkg::IDX_COUNT_B_1: rd_word = s_r.inst[0].cnt_b;
            alsb_pkg::IDX_RESTART_1: rd_word = s_r.inst[0].restart;
            alsb_pkg::IDX_HALF_MON_2: rd_word = half_mon(s_r.inst[1].half);
            alsb_pkg::IDX_DONE_A_2: rd_word = {15'h0000, s_r.inst[1].done_a};
            alsb_pkg::IDX_DONE_B_2: rd_word = {15'h0000, s_r.inst[1].done_b};
            alsb_pkg::IDX_COUNT_A_2: rd_word = s_r.inst[1].cnt_a;
            alsb_pkg::IDX_COUNT_B_2: rd_word = s_r.inst[1].cnt_b;
            alsb_pkg::IDX_RESTART_2: rd_word = s_r.inst[1].restart;
            alsb_pkg::IDX_IRQ_STATUS: rd_word = {12'h000, s_r.irq_stat};
            alsb_pkg::IDX_IRQ_MASK: rd_word = {12'h000, s_r.irq_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    // Write decode
    always_comb begin
        wr_done_a = '0;
        wr_done_b = '0;
        wr_restart = '0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (wr_go) begin
            wr_done_a[0] = idx == alsb_pkg::IDX_DONE_A_1;
            wr_done_b[0] = idx == alsb_pkg::IDX_DONE_B_1;
            wr_restart[0] = idx == alsb_pkg::IDX_RESTART_1;
            wr_done_a[1] = idx == alsb_pkg::IDX_DONE_A_2;
            wr_done_b[1] = idx == alsb_pkg::IDX_DONE_B_2;
            wr_restart[1] = idx == alsb_pkg::IDX_RESTART_2;
            wr_stat = idx == alsb_pkg::IDX_IRQ_STATUS;
            wr_mask = idx == alsb_pkg::IDX_IRQ_MASK;
        end
    end

    always_comb begin
        logic trig;
        logic sw;
        logic full;
        logic restart_edge;
        logic set_a;
        logic set_b;
        logic [15:0] new_req;
        logic [3:0] sel;
        logic [IRQ_W_L-1:0] ev;
        trig = 1'b0;
        sw = 1'b0;
        full = 1'b0;
        restart_edge = 1'b0;
        set_a = 1'b0;
        set_b = 1'b0;
        new_req = 16'h0000;
        sel = 4'h0;
        ev = '0;
        s_nxt = s_r;

        s_nxt.run_prev = ctrl_run;
        s_nxt.ext_s1 = ext_in;
        s_nxt.ext_s2 = s_r.ext_s1;
        s_nxt.ext_prev = s_r.ext_s2;

        for (int i = 0; i < alsb_pkg::NUM_INST; i++) begin // [R18]
            trig = is_trigger(setup[i].method);
            sel = setup[i].ext_select[3:0];
            set_a = 1'b0;
            set_b = 1'b0;
            // Switch source: external block rising edge or the command pulse
            if (ext_used(setup[i])) begin
                sw = s_r.ext_s2[sel] && !s_r.ext_prev[sel];
            end else begin
                sw = switch_request[i];
            end
            new_req = wr_restart[i] ? pwdata[15:0] : s_r.inst[i].restart;
            restart_edge = wr_restart[i] && s_r.inst[i].restart == 16'h0000
                           && new_req == alsb_pkg::RESTART_ASK;
            s_nxt.inst[i].restart = new_req;

            if (!ctrl_run) begin
                s_nxt.inst[i].half = alsb_pkg::ALSB_STOPPED; // [R5]
            end else if (run_start || restart_edge) begin
                s_nxt.inst[i].half = alsb_pkg::ALSB_HALF_A; // [R16]
                s_nxt.inst[i].first = 1'b0;
                s_nxt.inst[i].cnt_a = alsb_pkg::CNT_RESET; // [R13] [R14]
                s_nxt.inst[i].cnt_b = alsb_pkg::CNT_RESET; // [R13] [R14]
            end else if (setup[i].enable) begin
                if (trig && sw) begin
                    // Trigger mode: leave the current half and mark it done
                    if (s_r.inst[i].half == alsb_pkg::ALSB_HALF_A) begin
                        s_nxt.inst[i].half = alsb_pkg::ALSB_HALF_B;
                        s_nxt.inst[i].cnt_b = alsb_pkg::CNT_RESET; // [R15]
                        set_a = 1'b1; // [R8]
                    end else begin
                        s_nxt.inst[i].half = alsb_pkg::ALSB_HALF_A;
                        s_nxt.inst[i].cnt_a = alsb_pkg::CNT_RESET; // [R15]
                        set_b = 1'b1; // [R8]
                    end
                end else if (log_exec[i]) begin
                    if (s_r.inst[i].half == alsb_pkg::ALSB_HALF_A) begin
                        if (s_r.inst[i].first) begin
                            s_nxt.inst[i].cnt_a = alsb_pkg::CNT_FIRST; // [R12]
                        end else begin
                            s_nxt.inst[i].cnt_a = s_r.inst[i].cnt_a + 16'h0001;
                        end // [R11]
                        full = s_nxt.inst[i].cnt_a
                               == 16'(HALF_DEPTH);
                    end else begin
                        if (s_r.inst[i].first) begin
                            s_nxt.inst[i].cnt_b = alsb_pkg::CNT_FIRST; // [R12]
                        end else begin
                            s_nxt.inst[i].cnt_b = s_r.inst[i].cnt_b + 16'h0001;
                        end // [R11]
                        full = s_nxt.inst[i].cnt_b
                               == 16'(HALF_DEPTH);
                    end
                    s_nxt.inst[i].first = 1'b0;
                    // Trigger mode stays in the half at the half size; later executions count on past it
                    if (trig && full) begin
                        s_nxt.inst[i].cnt_a = s_r.inst[i].cnt_a;
                        s_nxt.inst[i].cnt_b = s_r.inst[i].cnt_b;
                        if (s_r.inst[i].half == alsb_pkg::ALSB_HALF_A) begin
                            s_nxt.inst[i].cnt_a = 16'(HALF_DEPTH);
                        end else begin
                            s_nxt.inst[i].cnt_b = 16'(HALF_DEPTH);
                        end
                    end else if (!trig && full) begin
                        s_nxt.inst[i].first = 1'b1;
                        if (s_r.inst[i].half == alsb_pkg::ALSB_HALF_A) begin
                            s_nxt.inst[i].half = alsb_pkg::ALSB_HALF_B;
                            set_a = 1'b1; // [R7]
                        end else begin
                            s_nxt.inst[i].half = alsb_pkg::ALSB_HALF_A;
                            set_b = 1'b1; // [R7]
                        end
                    end
                end
            end

            // Host clears with 0; a completion in the same cycle wins
            if (wr_done_a[i]) begin
                s_nxt.inst[i].done_a = pwdata[0];
            end
            if (wr_done_b[i]) begin
                s_nxt.inst[i].done_b = pwdata[0];
            end
            if (set_a) begin
                s_nxt.inst[i].done_a = 1'b1; // [R6]
            end
            if (set_b) begin
                s_nxt.inst[i].done_b = 1'b1; // [R6]
            end
            ev[2*i] = set_a;
            ev[2*i+1] = set_b;
        end

        // Sticky status, write one to clear, new events win
        if (wr_stat) begin
            s_nxt.irq_stat = s_r.irq_stat & ~pwdata[IRQ_W_L-1:0];
        end
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
        if (wr_mask) begin
            s_nxt.irq_mask = pwdata[IRQ_W_L-1:0];
        end
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

        // One wait state: ready rises on the second access cycle
        s_nxt.pready = psel && penable && !s_r.pready;
        s_nxt.pslverr = psel && penable && !s_r.pready && !rd_hit;
        s_nxt.prdata = (psel && penable && !s_r.pready && !pwrite) ?
                       {16'h0000, rd_word} : 32'h0000_0000;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_r <= '0;
            for (int i = 0; i < alsb_pkg::NUM_INST; i++) begin
                s_r.inst[i].done_a <= alsb_pkg::FLAG_RESET; // [R10]
                s_r.inst[i].done_b <= alsb_pkg::FLAG_RESET; // [R10]
                s_r.inst[i].half <= alsb_pkg::ALSB_STOPPED;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;

endmodule // alsb_top

// >>> src/alsb_pkg.sv
// Constants and types for the conversion logging status bank
// How it works
// [R1] Method monitor: 0 automatic, 1 trigger; 0 if logging disabled.
// [R2] Condition monitor: external input enabled 1, else 0; 0 if disabled.
// [R3] External input monitor shows selected block 0H to BH while running.
// [R4] External input monitor is 0 if logging or external input disabled.
// [R5] Storage monitor: 0 stopped, 1 filling A half, 2 filling B half.
// [R6] Separate done flags for A half and B half, 1 meaning completed.
// [R7] Automatic switching sets a half's flag once that half is full.
// [R8] Trigger switching sets a done flag at every half change.
// [R9] Host writes 0 to a done flag after copying that half out.
// [R10] Every done flag starts at 0.
// [R11] Each logging execution adds 1 to the counter of the active half.
// [R12] Automatic switching loads 1 on first execution after a half change.
// [R13] Counters clear when hardware logic control starts.
// [R14] Both counters clear on a 0-to-1 change of the restart request.
// [R15] Trigger switching clears the counter at every half change.
// [R16] Restart request 0-to-1 restarts logging at the first A half location.
// [R17] Any method setting other than 0 counts as trigger switching.
// [R18] Two identical independent instances, nothing shared between them; the code shares irq_stat, irq_mask and the irq output.
package alsb_pkg;

    localparam int NUM_INST = 2;
    localparam int HALF_DEPTH = 4096;
    localparam int APB_AW = 12;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_METHOD_MON_1 = 10'h0AE;
    localparam logic [9:0] IDX_COND_MON_1 = 10'h0AF;
    localparam logic [9:0] IDX_EXT_MON_1 = 10'h0B0;
    localparam logic [9:0] IDX_METHOD_MON_2 = 10'h0B8;
    localparam logic [9:0] IDX_COND_MON_2 = 10'h0B9;
    localparam logic [9:0] IDX_EXT_MON_2 = 10'h0BA;
    localparam logic [9:0] IDX_HALF_MON_1 = 10'h0BE;
    localparam logic [9:0] IDX_DONE_A_1 = 10'h0BF;
    localparam logic [9:0] IDX_DONE_B_1 = 10'h0C0;
    localparam logic [9:0] IDX_COUNT_A_1 = 10'h0C1;
    localparam logic [9:0] IDX_COUNT_B_1 = 10'h0C2;
    localparam logic [9:0] IDX_RESTART_1 = 10'h0C3;
    localparam logic [9:0] IDX_HALF_MON_2 = 10'h0C8;
    localparam logic [9:0] IDX_DONE_A_2 = 10'h0C9;
    localparam logic [9:0] IDX_DONE_B_2 = 10'h0CA;
    localparam logic [9:0] IDX_COUNT_A_2 = 10'h0CB;
    localparam logic [9:0] IDX_COUNT_B_2 = 10'h0CC;
    localparam logic [9:0] IDX_RESTART_2 = 10'h0CD;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0D0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0D1;

    // Interrupt bit layout: bit 2*i is A done, bit 2*i+1 is B done
    localparam int IRQ_W = 4;

    // Monitor encodings and reset values
    localparam logic [15:0] MON_STOPPED = 16'h0000;
    localparam logic [15:0] MON_HALF_A = 16'h0001;
    localparam logic [15:0] MON_HALF_B = 16'h0002;
    localparam logic [15:0] EXT_MAX = 16'h000B;
    localparam logic [15:0] RESTART_ASK = 16'h0001;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_FIRST = 16'h0001;
    localparam logic FLAG_RESET = 1'b0;

    typedef enum logic [1:0] {
        ALSB_STOPPED,
        ALSB_HALF_A,
        ALSB_HALF_B
    } alsb_half_t;

    // Per-instance settings coming from the logging setup logic
    typedef struct packed {
        logic enable;
        logic [15:0] method;
        logic [15:0] condition;
        logic [15:0] ext_select;
    } alsb_setup_t;

    // Per-instance state
    typedef struct packed {
        alsb_half_t half;
        logic first;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic done_a;
        logic done_b;
        logic [15:0] restart;
    } alsb_inst_t;

    typedef struct packed {
        alsb_inst_t [NUM_INST-1:0] inst;
        logic run_prev;
        logic [11:0] ext_s1;
        logic [11:0] ext_s2;
        logic [11:0] ext_prev;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } alsb_state_t;

endpackage

// >>> tb/alsb_host.sv
// Host side model: APB master used by software to reach the status bank
`timescale 1ns/1ps
module alsb_host (
    // Clock
    input wire logic clk_sys,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    end

    // One transfer; ok stays low if no answer comes within the bound
    task automatic xfer(input logic w, input logic [9:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err,
        output logic ok);
        int n;
        n = 0;
        ok = 1'h0;
        @(posedge clk_sys);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        pstrb <= 4'hF;
        @(posedge clk_sys);
        penable <= 1'h1;
        while (n < 20 && ok !== 1'h1) begin
            @(posedge clk_sys);
            ok = (pready === 1'h1);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Released lines do not keep the old value
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
endmodule // alsb_host

// >>> tb/alsb_chk.sv
// Bus and interrupt checks for the logging status bank
`timescale 1ns/1ps
module alsb_chk #(
    parameter int HALF_DEPTH = 4096
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [alsb_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events and interrupt
    input wire logic [alsb_pkg::NUM_INST-1:0] log_exec,
    input wire logic [alsb_pkg::NUM_INST-1:0] switch_request,
    input wire logic [11:0] ext_in,
    input wire logic irq
);
    logic [9:0] idx;
    logic mapped;
    logic cause;
    assign idx = paddr[11:2];
    // Map written out here so a wrong package constant still shows
    assign mapped = idx inside {10'h0AE, 10'h0AF, 10'h0B0, 10'h0B8, 10'h0B9,
        10'h0BA, [10'h0BE:10'h0C3], [10'h0C8:10'h0CD], 10'h0D0, 10'h0D1};
    // External blocks switch halves too, a few cycles after the pin rises
    assign cause = (|log_exec) || (|switch_request) || (pready && pwrite)
        || (|ext_in);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_one_wait; psel && penable && !pready |=> pready; endproperty
    property p_one_cycle; pready |=> !pready; endproperty
    property p_in_access; pready |-> psel && penable; endproperty
    property p_err_map; pready |-> pslverr == !mapped; endproperty
    property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
    property p_idle_zero; !(pready && !pwrite) |-> prdata == 32'h0; endproperty
    property p_upper_zero; pready |-> prdata[31:16] == 16'h0; endproperty
    property p_irq_rise;
        $rose(irq) |-> $past(cause) || $past(cause, 2) || $past(cause, 3);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2);
    endproperty

    a_one_wait: assert property (p_one_wait) else $error("late answer");
    a_one_cycle: assert property (p_one_cycle) else $error("ready too long");
    a_in_access: assert property (p_in_access) else $error("stray ready");
    a_err_map: assert property (p_err_map) else $error("error flag wrong");
    a_err_zero: assert property (p_err_zero) else $error("error data");
    a_idle_zero: assert property (p_idle_zero) else $error("idle data");
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits");
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq rise");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fall");

    c_irq: cover property ($rose(irq));
    c_err: cover property (pready && pslverr);
    c_read: cover property (pready && !pwrite && prdata != 32'h0);
endmodule // alsb_chk

bind alsb_top alsb_chk #(.HALF_DEPTH(HALF_DEPTH)) alsb_chk_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .log_exec(log_exec),
    .switch_request(switch_request), .ext_in(ext_in), .irq(irq));

// >>> tb/tb_top.sv
// Self-checking bench for the logging status bank
`timescale 1ns/1ps
module tb_top;
    // Short halves keep the run brief
    localparam int H = 8;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic ctrl_run, irq;
    logic [11:0] paddr, ext_in;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    alsb_pkg::alsb_setup_t [1:0] setup;
    logic [1:0] log_exec, switch_request;
    int bad_count, checked;
    logic [9:0] flg [4] = '{10'h0BF, 10'h0C0, 10'h0C9, 10'h0CA};
    logic [15:0] mth [3] = '{16'h1, 16'h7, 16'h0};

    alsb_top #(.HALF_DEPTH(H)) alsb_top_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctrl_run(ctrl_run), .setup(setup),
        .log_exec(log_exec), .switch_request(switch_request),
        .ext_in(ext_in), .irq(irq));
    alsb_host alsb_host_i (.clk_sys(clk_sys), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("bad_count=%0d checked=%0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [9:0] i,
        input logic [31:0] wd, input logic [31:0] exp, input logic err);
        logic [31:0] d;
        logic e;
        logic ok;
        alsb_host_i.xfer(w, i, wd, d, e, ok);
        if (ok !== 1'h1) begin
            bad_count++;
            results();
        end else begin
            chk(d, exp);
            chk_bit(e, err);
        end
    endtask

    task automatic rd(input logic [9:0] i, input logic [31:0] exp);
        acc(1'h0, i, 32'h0, exp, 1'h0);
    endtask

    task automatic wr(input logic [9:0] i, input logic [31:0] wd);
        acc(1'h1, i, wd, 32'h0, 1'h0);
    endtask

    // Holds a pulse input high for n back-to-back sampling edges
    task automatic ev(input int i, input logic sw, input int n);
        @(posedge clk_sys);
        if (sw) switch_request[i] <= 1'h1;
        else log_exec[i] <= 1'h1;
        repeat (n) @(posedge clk_sys);
        log_exec <= 2'h0;
        switch_request <= 2'h0;
    endtask

    initial begin
        {rst_n, ctrl_run, log_exec, switch_request, ext_in} = '0;
        setup[0] = '{enable: 1'h1, method: 16'h0, condition: 16'h1,
            ext_select: 16'h5};
        setup[1] = '{enable: 1'h0, method: 16'h1, condition: 16'h1,
            ext_select: 16'h7};
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'h1;
        foreach (flg[k]) rd(flg[k], 32'h0);
        rd(10'h0BE, 32'h0);
        @(posedge clk_sys);
        ctrl_run <= 1'h1;
        repeat (3) @(posedge clk_sys);
        rd(10'h0AF, 32'h1);
        rd(10'h0B0, 32'h5);
        rd(10'h0B9, 32'h0);
        rd(10'h0BA, 32'h0);
        rd(10'h0B8, 32'h0);
        rd(10'h0BE, 32'h1);
        foreach (mth[k]) begin
            @(posedge clk_sys);
            setup[0].method <= mth[k];
            rd(10'h0AE, {31'h0, mth[k] != 16'h0});
        end
        setup[0].condition <= 16'h0;
        rd(10'h0B0, 32'h0);
        setup[0].condition <= 16'h1;
        wr(10'h0D1, 32'hF);
        ev(0, 1'h0, H + 1);
        rd(10'h0BF, 32'h1);
        rd(10'h0C0, 32'h0);
        rd(10'h0BE, 32'h2);
        rd(10'h0C1, H);
        rd(10'h0C2, 32'h1);
        chk_bit(irq, 1'h1);
        wr(10'h0BF, 32'h0);
        rd(10'h0BF, 32'h0);
        wr(10'h0D0, 32'h1);
        rd(10'h0D0, 32'h0);
        chk_bit(irq, 1'h0);
        wr(10'h0C3, 32'h1);
        rd(10'h0C1, 32'h0);
        rd(10'h0C2, 32'h0);
        rd(10'h0BE, 32'h1);
        rd(10'h0C3, 32'h1);
        wr(10'h0C3, 32'h0);
        wr(10'h0C1, 32'h55);
        ev(0, 1'h0, 3);
        rd(10'h0C1, 32'h3);
        acc(1'h0, 10'h0A0, 32'h0, 32'h0, 1'h1);
        ctrl_run <= 1'h0;
        rd(10'h0BE, 32'h0);
        setup[1].enable <= 1'h1;
        setup[1].condition <= 16'h0;
        ctrl_run <= 1'h1;
        repeat (3) @(posedge clk_sys);
        rd(10'h0C1, 32'h0);
        wr(10'h0D1, 32'hB);
        ev(1, 1'h0, 3);
        rd(10'h0CB, 32'h3);
        rd(10'h0C1, 32'h0);
        ev(1, 1'h1, 1);
        rd(10'h0C9, 32'h1);
        rd(10'h0C8, 32'h2);
        rd(10'h0CC, 32'h0);
        rd(10'h0D0, 32'h4);
        chk_bit(irq, 1'h0);
        wr(10'h0D1, 32'hF);
        rd(10'h0D0, 32'h4);
        chk_bit(irq, 1'h1);
        ev(1, 1'h0, 2);
        rd(10'h0CC, 32'h2);
        // External block 3 now switches instance 2 back to the A half
        setup[1].condition <= 16'h1;
        setup[1].ext_select <= 16'h3;
        @(posedge clk_sys);
        ext_in <= 12'h008;
        repeat (4) @(posedge clk_sys);
        rd(10'h0CA, 32'h1);
        rd(10'h0C8, 32'h1);
        rd(10'h0CB, 32'h0);
        rd(10'h0BA, 32'h3);
        rd(10'h0B9, 32'h1);
        rd(10'h0D0, 32'hC);
        results();
    end
endmodule // tb_top
